// ===== verilog/rps_pin_select.v
// peripheral pin select: output function muxes for pins 32..35 and
// pin selectors for the second spi clock and data inputs.
// assumes peripheral outputs are on ref_clk; pin inputs are asynchronous.
`timescale 1ns/1ps
`include "rps_map.vh"
// Contract
// - pin 32 code in out0 bits 5..0
// - out0/out1 bits 15,14,7,6 ignore writes, read zero
// - code zero keeps ordinary port drive
// - codes 1..4 route uart tx and rts
// - codes 5..7 route spi one outputs
// - codes 8..10 route spi two outputs
// - codes 16..19 route compare outputs one-four
// - codes 24..26, 50 route comparators
// - codes 45, 46 route time base sync
// - code 49 routes reference clock
// - codes 51..54 route pwm 4/5 high, low
// - in22 holds spi2 clock and data selectors
// - selector n picks pin n, zero grounds
module rps_pin_select #(
  parameter PIN_COUNT = 181
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [`RPS_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [15:0] reg_rdata,
  input wire uart_one_transmit,
  input wire uart_one_request_to_send,
  input wire uart_two_transmit,
  input wire uart_two_request_to_send,
  input wire spi_one_data_out,
  input wire spi_one_clock_out,
  input wire spi_one_slave_select,
  input wire spi_two_data_out,
  input wire spi_two_clock_out,
  input wire spi_two_slave_select,
  input wire compare_out_one,
  input wire compare_out_two,
  input wire compare_out_three,
  input wire compare_out_four,
  input wire comparator_out_one,
  input wire comparator_out_two,
  input wire comparator_out_three,
  input wire comparator_out_four,
  input wire primary_timebase_sync_out,
  input wire secondary_timebase_sync_out,
  input wire reference_clock_out,
  input wire pwm_gen4_high_out,
  input wire pwm_gen4_low_out,
  input wire pwm_gen5_high_out,
  input wire pwm_gen5_low_out,
  input wire [3:0] port_out,
  output reg [3:0] remappable_pin_out,
  output reg [3:0] remappable_pin_remapped,
  input wire [PIN_COUNT:1] remappable_pin_in,
  output reg spi2_clock_in,
  output reg spi2_data_in
);

  reg [15:0] spi2_input_pin_select;
  reg [15:0] output_select_pins_32_33;
  reg [15:0] output_select_pins_34_35;
  reg [PIN_COUNT:1] pin_meta;
  reg [PIN_COUNT:1] pin_sync;
  reg [7:0] spi2_clock_input_selector;
  reg [7:0] spi2_data_input_selector;
  reg [5:0] pin_function_code [0:3];
  wire [3:0] next_pin_out;
  wire [3:0] next_remapped;
  wire next_sck;
  wire next_sdi;
  genvar g;

  // register port, one word per address
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      spi2_input_pin_select <= `RPS_IN_RESET;
      output_select_pins_32_33 <= `RPS_OUT_RESET;
      output_select_pins_34_35 <= `RPS_OUT_RESET;
      reg_rdata <= 16'h0000;
    end else begin
      if (reg_write) begin
        case (reg_addr)
          `RPS_ADDR_IN22: spi2_input_pin_select <= reg_wdata;
          `RPS_ADDR_OUT0:
            output_select_pins_32_33 <= reg_wdata & `RPS_OUT_MASK;
          `RPS_ADDR_OUT1:
            output_select_pins_34_35 <= reg_wdata & `RPS_OUT_MASK;
          default: ;
        endcase
      end
      // unmapped addresses read as zero
      if (reg_read) begin
        case (reg_addr)
          `RPS_ADDR_IN22: reg_rdata <= spi2_input_pin_select;
          `RPS_ADDR_OUT0: reg_rdata <= output_select_pins_32_33;
          `RPS_ADDR_OUT1: reg_rdata <= output_select_pins_34_35;
          default: reg_rdata <= 16'h0000;
        endcase
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  always @* begin
    pin_function_code[0] =
      output_select_pins_32_33[`RPS_LO_LSB +: 6];
    pin_function_code[1] =
      output_select_pins_32_33[`RPS_HI_LSB +: 6];
    pin_function_code[2] =
      output_select_pins_34_35[`RPS_LO_LSB +: 6];
    pin_function_code[3] =
      output_select_pins_34_35[`RPS_HI_LSB +: 6];
    spi2_clock_input_selector = spi2_input_pin_select[`RPS_HI_LSB +: 8];
    spi2_data_input_selector = spi2_input_pin_select[`RPS_LO_LSB +: 8];
  end

  // one decoder per pin; each pin decodes on its own, so a code change
  // on one pin cannot disturb the routing of another
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_pin_mux
      rps_out_mux u_rps_out_mux (
        .fn_code(pin_function_code[g]),
        .port_level(port_out[g]),
        .uart_one_transmit(uart_one_transmit),
        .uart_one_request_to_send(uart_one_request_to_send),
        .uart_two_transmit(uart_two_transmit),
        .uart_two_request_to_send(uart_two_request_to_send),
        .spi_one_data_out(spi_one_data_out),
        .spi_one_clock_out(spi_one_clock_out),
        .spi_one_slave_select(spi_one_slave_select),
        .spi_two_data_out(spi_two_data_out),
        .spi_two_clock_out(spi_two_clock_out),
        .spi_two_slave_select(spi_two_slave_select),
        .compare_out_one(compare_out_one),
        .compare_out_two(compare_out_two),
        .compare_out_three(compare_out_three),
        .compare_out_four(compare_out_four),
        .comparator_out_one(comparator_out_one),
        .comparator_out_two(comparator_out_two),
        .comparator_out_three(comparator_out_three),
        .comparator_out_four(comparator_out_four),
        .primary_timebase_sync_out(primary_timebase_sync_out),
        .secondary_timebase_sync_out(secondary_timebase_sync_out),
        .reference_clock_out(reference_clock_out),
        .pwm_gen4_high_out(pwm_gen4_high_out),
        .pwm_gen4_low_out(pwm_gen4_low_out),
        .pwm_gen5_high_out(pwm_gen5_high_out),
        .pwm_gen5_low_out(pwm_gen5_low_out),
        .pin_level(next_pin_out[g]),
        .pin_remapped(next_remapped[g])
      );
    end
  endgenerate

  // spi2 clock and data inputs share one selector design
  rps_in_select #(.PIN_COUNT(PIN_COUNT)) u_rps_in_select_clock (
    .pin_sync(pin_sync),
    .selector(spi2_clock_input_selector),
    .level(next_sck)
  );
  rps_in_select #(.PIN_COUNT(PIN_COUNT)) u_rps_in_select_data (
    .pin_sync(pin_sync),
    .selector(spi2_data_input_selector),
    .level(next_sdi)
  );

  // pins are asynchronous: two flops before the selector looks at them
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_meta <= {PIN_COUNT{1'b0}};
      pin_sync <= {PIN_COUNT{1'b0}};
    end else begin
      pin_meta <= remappable_pin_in;
      pin_sync <= pin_meta;
    end
  end

  // registered outputs decouple decode hazards from the pins
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      remappable_pin_out <= 4'h0;
      remappable_pin_remapped <= 4'h0;
      spi2_clock_in <= 1'b0;
      spi2_data_in <= 1'b0;
    end else begin
      remappable_pin_out <= next_pin_out;
      remappable_pin_remapped <= next_remapped;
      spi2_clock_in <= next_sck;
      spi2_data_in <= next_sdi;
    end
  end

endmodule // rps_pin_select

// output function decode for one remappable pin; purely combinational,
// the caller registers the result
module rps_out_mux #(
  parameter CODE_W = 6
) (
  input wire [CODE_W-1:0] fn_code,
  input wire port_level,
  input wire uart_one_transmit,
  input wire uart_one_request_to_send,
  input wire uart_two_transmit,
  input wire uart_two_request_to_send,
  input wire spi_one_data_out,
  input wire spi_one_clock_out,
  input wire spi_one_slave_select,
  input wire spi_two_data_out,
  input wire spi_two_clock_out,
  input wire spi_two_slave_select,
  input wire compare_out_one,
  input wire compare_out_two,
  input wire compare_out_three,
  input wire compare_out_four,
  input wire comparator_out_one,
  input wire comparator_out_two,
  input wire comparator_out_three,
  input wire comparator_out_four,
  input wire primary_timebase_sync_out,
  input wire secondary_timebase_sync_out,
  input wire reference_clock_out,
  input wire pwm_gen4_high_out,
  input wire pwm_gen4_low_out,
  input wire pwm_gen5_high_out,
  input wire pwm_gen5_low_out,
  output reg pin_level,
  output reg pin_remapped
);

  always @* begin
    pin_level = port_level;
    pin_remapped = 1'b1;
    case (fn_code)
      `RPS_FN_UART_ONE_TRANSMIT: pin_level = uart_one_transmit;
      `RPS_FN_UART_ONE_REQUEST_TO_SEND: pin_level = uart_one_request_to_send;
      `RPS_FN_UART_TWO_TRANSMIT: pin_level = uart_two_transmit;
      `RPS_FN_UART_TWO_REQUEST_TO_SEND: pin_level = uart_two_request_to_send;
      `RPS_FN_SPI_ONE_DATA_OUT: pin_level = spi_one_data_out;
      `RPS_FN_SPI_ONE_CLOCK_OUT: pin_level = spi_one_clock_out;
      `RPS_FN_SS1: pin_level = spi_one_slave_select;
      `RPS_FN_SPI_TWO_DATA_OUT: pin_level = spi_two_data_out;
      `RPS_FN_SPI_TWO_CLOCK_OUT: pin_level = spi_two_clock_out;
      `RPS_FN_SS2: pin_level = spi_two_slave_select;
      `RPS_FN_OC1: pin_level = compare_out_one;
      `RPS_FN_OC2: pin_level = compare_out_two;
      `RPS_FN_OC3: pin_level = compare_out_three;
      `RPS_FN_OC4: pin_level = compare_out_four;
      `RPS_FN_CMP1: pin_level = comparator_out_one;
      `RPS_FN_CMP2: pin_level = comparator_out_two;
      `RPS_FN_CMP3: pin_level = comparator_out_three;
      `RPS_FN_CMP4: pin_level = comparator_out_four;
      `RPS_FN_SYNC1: pin_level = primary_timebase_sync_out;
      `RPS_FN_SYNC2: pin_level = secondary_timebase_sync_out;
      `RPS_FN_REFCLK: pin_level = reference_clock_out;
      `RPS_FN_PWM_GEN4_HIGH_OUT: pin_level = pwm_gen4_high_out;
      `RPS_FN_PWM_GEN4_LOW_OUT: pin_level = pwm_gen4_low_out;
      `RPS_FN_PWM_GEN5_HIGH_OUT: pin_level = pwm_gen5_high_out;
      `RPS_FN_PWM_GEN5_LOW_OUT: pin_level = pwm_gen5_low_out;
      default: begin
        // code zero and every unassigned code fall back to the port
        pin_remapped = 1'b0;
        pin_level = port_level;
      end
    endcase
  end

endmodule // rps_out_mux

// pin number selector for one peripheral input; reads synchronised pins
module rps_in_select #(
  parameter PIN_COUNT = 181,
  parameter SEL_W = 8
) (
  input wire [PIN_COUNT:1] pin_sync,
  input wire [SEL_W-1:0] selector,
  output reg level
);

  integer i;

  // zero and numbers past the last pin leave the input at ground
  always @* begin
    level = 1'b0;
    for (i = 1; i <= PIN_COUNT; i = i + 1) begin
      if (selector == i[SEL_W-1:0]) begin
        level = pin_sync[i];
      end
    end
  end

endmodule // rps_in_select

// ===== verilog/rps_map.vh
// register map, field positions and function codes of the pin select block
// assumes a 16-bit register port with small word addresses
`ifndef RPS_MAP_VH
`define RPS_MAP_VH
`define RPS_ADDR_W 4
`define RPS_ADDR_IN22 4'h0
`define RPS_ADDR_OUT0 4'h1
`define RPS_ADDR_OUT1 4'h2
`define RPS_OUT_MASK 16'h3f3f
`define RPS_IN_RESET 16'h0000
`define RPS_OUT_RESET 16'h0000
`define RPS_HI_LSB 8
`define RPS_LO_LSB 0
`define RPS_FN_PORT 6'h00
`define RPS_FN_UART_ONE_TRANSMIT 6'h01
`define RPS_FN_UART_ONE_REQUEST_TO_SEND 6'h02
`define RPS_FN_UART_TWO_TRANSMIT 6'h03
`define RPS_FN_UART_TWO_REQUEST_TO_SEND 6'h04
`define RPS_FN_SPI_ONE_DATA_OUT 6'h05
`define RPS_FN_SPI_ONE_CLOCK_OUT 6'h06
`define RPS_FN_SS1 6'h07
`define RPS_FN_SPI_TWO_DATA_OUT 6'h08
`define RPS_FN_SPI_TWO_CLOCK_OUT 6'h09
`define RPS_FN_SS2 6'h0a
`define RPS_FN_OC1 6'h10
`define RPS_FN_OC2 6'h11
`define RPS_FN_OC3 6'h12
`define RPS_FN_OC4 6'h13
`define RPS_FN_CMP1 6'h18
`define RPS_FN_CMP2 6'h19
`define RPS_FN_CMP3 6'h1a
`define RPS_FN_SYNC1 6'h2d
`define RPS_FN_SYNC2 6'h2e
`define RPS_FN_REFCLK 6'h31
`define RPS_FN_CMP4 6'h32
`define RPS_FN_PWM_GEN4_HIGH_OUT 6'h33
`define RPS_FN_PWM_GEN4_LOW_OUT 6'h34
`define RPS_FN_PWM_GEN5_HIGH_OUT 6'h35
`define RPS_FN_PWM_GEN5_LOW_OUT 6'h36
`define RPS_PIN_MAX 8'hb5
`endif

// ===== tb/rps_pin_select_properties.sv
// port assertions for the pin select block
// assumes one clock and a synchronous rst_n
`timescale 1ns/1ps
module rps_pin_select_chk #(parameter PIN_COUNT = 181) (
  input wire ref_clk,
  input wire rst_n,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [15:0] reg_rdata,
  input wire [3:0] remappable_pin_remapped,
  input wire [PIN_COUNT:1] remappable_pin_in,
  input wire spi2_clock_in
);
  reg [5:0] c0;
  reg [7:0] sc;
  wire m0 = remappable_pin_remapped[0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // shadows of the pin 32 code and the spi2 clock selector
  always @(posedge ref_clk) begin
    if (!rst_n || reg_write && reg_addr == 4'h1)
      c0 <= rst_n ? reg_wdata[5:0] : 6'h00;
    if (!rst_n || reg_write && reg_addr == 4'h0)
      sc <= rst_n ? reg_wdata[15:8] : 8'h00;
  end
  chk_mask_zero: assert property (
    reg_read && |reg_addr |=> !(reg_rdata & 16'hc0c0)) else $error("mask");
  chk_code_read: assert property (
    reg_read && reg_addr == 4'h1 |=> reg_rdata[5:0] == c0) else $error("rd");
  chk_port_idle: assert property (
    !c0 |=> !m0) else $error("port");
  chk_uart_route: assert property (
    c0 == 6'h01 |=> m0) else $error("uart");
  chk_spare_code: assert property (
    c0 == 6'h0b || c0 == 6'h3f |=> !m0) else $error("spare");
  chk_code_next: assert property (
    reg_write && reg_addr == 4'h1 && reg_wdata[5:0] == 6'h01 |-> ##2 m0)
    else $error("late");
  chk_spi2_gnd: assert property (
    !sc || sc > PIN_COUNT |=> !spi2_clock_in) else $error("gnd");
  chk_spi2_pick: assert property (
    sc == 8'h05 |=> spi2_clock_in == $past(remappable_pin_in[5], 3))
    else $error("pick");
endmodule // rps_pin_select_chk
bind rps_pin_select rps_pin_select_chk #(.PIN_COUNT(PIN_COUNT)) u_chk (.*);

// ===== tb/rps_far_end.sv
// far-side model: peripheral output levels and pin levels
// assumes ref_clk; levels change just after each edge
`timescale 1ns/1ps
module rps_far_end #(parameter PIN_COUNT = 181) (
  input wire ref_clk,
  output reg [24:0] periph = 25'h0000001,
  output reg [PIN_COUNT:1] pins = 'h5
);
  // scrambled shifts, so a wrong selection differs within a few cycles
  always @(posedge ref_clk) begin
    periph <= {periph[23:0], periph[24] ^ periph[21]};
    pins <= {pins[PIN_COUNT-1:1], pins[PIN_COUNT] ^ pins[1]};
  end
endmodule // rps_far_end

// ===== tb/tb_rps_pin_select.sv
// bench for the pin select block with its far-side model
// assumes 250 MHz ref_clk and rst_n low for 20 cycles
`timescale 1ns/1ps
module tb_rps_pin_select;
  localparam PC = 12;
  localparam [149:0] CODES = {6'h36, 6'h35, 6'h34, 6'h33, 6'h31,
    6'h2e, 6'h2d, 6'h32, 6'h1a, 6'h19, 6'h18, 6'h13, 6'h12,
    6'h11, 6'h10, 6'h0a, 6'h09, 6'h08, 6'h07, 6'h06, 6'h05,
    6'h04, 6'h03, 6'h02, 6'h01};
  reg ref_clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0;
  reg [3:0] a = 4'h0, po = 4'h0;
  reg [15:0] d = 16'h0000;
  reg [24:0] pq;
  reg [PC:1] h1, h2, h3;
  wire [15:0] q;
  wire [24:0] p;
  wire [PC:1] pins;
  wire [3:0] pin, rm;
  wire sck, sdi;
  integer n_errors = 0, comparisons = 0, cyc = 0, i, k;
  rps_far_end #(.PIN_COUNT(PC)) u_rps_far_end (.ref_clk(ref_clk),
    .periph(p), .pins(pins));
  rps_pin_select #(.PIN_COUNT(PC)) u_rps_pin_select (.ref_clk(ref_clk),
    .rst_n(rst_n), .reg_addr(a), .reg_wdata(d), .reg_write(we),
    .reg_read(re), .reg_rdata(q), .uart_one_transmit(p[0]),
    .uart_one_request_to_send(p[1]), .uart_two_transmit(p[2]),
    .uart_two_request_to_send(p[3]), .spi_one_data_out(p[4]),
    .spi_one_clock_out(p[5]), .spi_one_slave_select(p[6]),
    .spi_two_data_out(p[7]), .spi_two_clock_out(p[8]),
    .spi_two_slave_select(p[9]), .compare_out_one(p[10]),
    .compare_out_two(p[11]), .compare_out_three(p[12]),
    .compare_out_four(p[13]), .comparator_out_one(p[14]),
    .comparator_out_two(p[15]), .comparator_out_three(p[16]),
    .comparator_out_four(p[17]), .primary_timebase_sync_out(p[18]),
    .secondary_timebase_sync_out(p[19]), .reference_clock_out(p[20]),
    .pwm_gen4_high_out(p[21]), .pwm_gen4_low_out(p[22]),
    .pwm_gen5_high_out(p[23]), .pwm_gen5_low_out(p[24]), .port_out(po),
    .remappable_pin_out(pin), .remappable_pin_remapped(rm),
    .remappable_pin_in(pins), .spi2_clock_in(sck), .spi2_data_in(sdi));
  task ck(input [15:0] g, input [15:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task wr(input [3:0] x, input [15:0] y);
    begin
      a <= x;
      d <= y;
      we <= 1'b1;
      @(posedge ref_clk) we <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task rd(input [3:0] x, input [15:0] e);
    begin
      a <= x;
      re <= 1'b1;
      @(posedge ref_clk) re <= 1'b0;
      @(negedge ref_clk) ck(q, e);
      @(posedge ref_clk);
    end
  endtask
  task t_regs;
    begin
      rd(4'h1, 16'h0000);
      wr(4'h1, 16'hffff);
      rd(4'h1, 16'h3f3f);
      wr(4'h2, 16'hf5ee);
      rd(4'h2, 16'h352e);
      wr(4'h0, 16'hb5ff);
      rd(4'h0, 16'hb5ff);
      wr(4'h9, 16'h1234);
      rd(4'h9, 16'h0000);
    end
  endtask
  task t_codes;
    for (i = 0; i < 25; i = i + 1) begin
      wr(4'h1, {2'b00, CODES[6*i +: 6], 2'b00, CODES[6*i +: 6]});
      for (k = 0; k < 3; k = k + 1) begin
        @(negedge ref_clk);
        ck(16'({rm[1:0], pin[1:0]}), 16'({2'b11, pq[i], pq[i]}));
        @(posedge ref_clk);
      end
    end
  endtask
  task t_port;
    begin
      po <= 4'h5;
      wr(4'h2, 16'h0000);
      wr(4'h1, 16'h3f0b);
      @(negedge ref_clk) ck(16'({rm, pin}), 16'h0005);
      @(posedge ref_clk) po <= 4'ha;
      wr(4'h2, 16'h3610);
      @(negedge ref_clk);
      ck(16'({rm, pin}), 16'({4'hc, pq[24], pq[10], 2'b10}));
      @(posedge ref_clk);
    end
  endtask
  task t_spi2;
    begin
      wr(4'h0, 16'h050c);
      for (k = 0; k < 6; k = k + 1) begin
        @(negedge ref_clk) ck(16'({sck, sdi}), 16'({h3[5], h3[12]}));
        @(posedge ref_clk);
      end
      wr(4'h0, 16'h00ff);
      @(negedge ref_clk) ck(16'({sck, sdi}), 16'h0000);
      @(posedge ref_clk);
    end
  endtask
  task conclude;
    begin
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial forever #2 ref_clk = ~ref_clk;
  // pin history: the input path is two sync stages plus an output flop
  always @(posedge ref_clk) begin
    pq <= p;
    h1 <= pins;
    h2 <= h1;
    h3 <= h2;
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors = n_errors + 1;
      conclude;
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs;
    t_codes;
    t_port;
    t_spi2;
    conclude;
  end
endmodule // tb_rps_pin_select
